//--- logic/ncqdh_defs.svh
// Offsets, field positions, codes and reset values of the deadline-handling command block.
`ifndef NCQDH_DEFS_SVH
`define NCQDH_DEFS_SVH

// Register byte offsets on the APB port.
`define NCQDH_OFF_FEATURE 8'h00
`define NCQDH_OFF_SECCOUNT 8'h04
`define NCQDH_OFF_SECNUM 8'h08
`define NCQDH_OFF_DEVHEAD 8'h0c
`define NCQDH_OFF_COMMAND 8'h10
`define NCQDH_OFF_STATUS 8'h14
`define NCQDH_OFF_ERROR 8'h18
`define NCQDH_OFF_CTRL 8'h1c
`define NCQDH_OFF_ABTYPE 8'h20
`define NCQDH_OFF_POLICY 8'h24
`define NCQDH_OFF_SDBMASK 8'h28

// Feature byte fields.
`define NCQDH_FEAT_SUB_HI 3
`define NCQDH_FEAT_SUB_LO 0
`define NCQDH_FEAT_WDEADLINE 4
`define NCQDH_FEAT_RDEADLINE 5

// Tag fields: own tag in sector count, target tag in sector number.
`define NCQDH_TAG_HI 7
`define NCQDH_TAG_LO 3

// Control and policy bits.
`define NCQDH_CTRL_NCQ_EN 0
`define NCQDH_POL_WR 0
`define NCQDH_POL_RD 1
`define NCQDH_ABTYPE_HI 3

// Codes.
`define NCQDH_CMD_QMGMT 8'h63
`define NCQDH_SUB_DEADLINE 4'h1
`define NCQDH_PRIORITY_ISOCH 2'h1

// Status byte positions.
`define NCQDH_ST_BUSY 7
`define NCQDH_ST_READY 6
`define NCQDH_ST_FAULT 5
`define NCQDH_ST_SEEKDONE 4
`define NCQDH_ST_DATAREQ 3
`define NCQDH_ST_ERR 0

// Error byte positions.
`define NCQDH_ER_ABORTED 2

// Reset values.
`define NCQDH_RST_BYTE 8'h00
`define NCQDH_RST_STATUS 8'h50
`define NCQDH_RST_WORD 32'h0000_0000

`endif

//--- logic/ncqdh_pkg.sv
// Types shared by the deadline-handling command block.
package ncqdh_pkg;
   typedef enum logic [1:0] {
      st_idle,
      st_eval,
      st_send
   } ncqdh_state_t;

   typedef logic [4:0] ncqdh_tag_t;
endpackage

//--- logic/ncqdh_dl_if.sv
// Carrier between the command decoder and the deadline monitor.
`timescale 1ns/100ps
interface ncqdh_dl_if;
   logic policy_load;
   logic policy_wr;
   logic policy_rd;
   logic miss_valid;
   logic miss_write;
   logic [1:0] miss_priority;
   logic wr_enf;
   logic rd_enf;
   logic abort_all;

   modport ctl (
      output policy_load, policy_wr, policy_rd, miss_valid, miss_write, miss_priority,
      input wr_enf, rd_enf, abort_all
   );
   modport mon (
      input policy_load, policy_wr, policy_rd, miss_valid, miss_write, miss_priority,
      output wr_enf, rd_enf, abort_all
   );
endinterface

//--- logic/ncqdh_deadline_mon.sv
// Holds the read and write deadline policies and decides when a missed deadline aborts all.
`timescale 1ns/100ps
`include "ncqdh_defs.svh"
module ncqdh_deadline_mon (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Link to the command decoder.
   ncqdh_dl_if.mon dl
);
   logic wr_enf_ff, nxt_wr_enf;
   logic rd_enf_ff, nxt_rd_enf;
   logic abort_ff, nxt_abort;
   logic iso;

   // Policies change only when a deadline-handling command completes cleanly.
   always_comb begin
      nxt_wr_enf = wr_enf_ff;
      nxt_rd_enf = rd_enf_ff;
      if (dl.policy_load) begin
         nxt_wr_enf = dl.policy_wr;
         nxt_rd_enf = dl.policy_rd;
      end
   end

   // A miss on a command of another priority never aborts, whatever the policy says.
   assign iso = (dl.miss_priority == `NCQDH_PRIORITY_ISOCH);

   // With a policy bit clear the miss is tolerated and simply passes.
   always_comb begin
      nxt_abort = 1'b0;
      if (dl.miss_valid && iso) begin
         if (dl.miss_write) begin
            nxt_abort = wr_enf_ff;
         end else begin
            nxt_abort = rd_enf_ff;
         end
      end
   end

   // Registers of the monitor.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_enf_ff <= 1'b0;
         rd_enf_ff <= 1'b0;
         abort_ff <= 1'b0;
      end else begin
         wr_enf_ff <= nxt_wr_enf;
         rd_enf_ff <= nxt_rd_enf;
         abort_ff <= nxt_abort;
      end
   end

   assign dl.wr_enf = wr_enf_ff;
   assign dl.rd_enf = rd_enf_ff;
   assign dl.abort_all = abort_ff;
endmodule

//--- logic/ncqdh_cmd.sv
// Deadline-handling queue-management command decoder with APB shadow registers.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "ncqdh_defs.svh"
module ncqdh_cmd #(
   parameter int QUEUE_DEPTH = 32,
   parameter int ABORT_TYPES = 2
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Other queued completions offered by the queue engine.
   input wire logic [31:0] other_done_mask,
   output logic other_done_taken,
   // Set Device Bits FIS request toward the transport.
   output logic sdb_valid,
   input wire logic sdb_ready,
   output logic [31:0] sdb_done_mask,
   output logic [7:0] sdb_status_flags,
   output logic [7:0] sdb_error_flags,
   // Completion timer misses reported by the queued-command engine.
   input wire logic deadline_miss,
   input wire logic deadline_miss_write,
   input wire logic [1:0] deadline_miss_priority,
   output logic abort_all_outstanding
);
   ncqdh_dl_if dl();

   ncqdh_pkg::ncqdh_state_t state_ff, nxt_state;
   logic [7:0] feature_ff, nxt_feature;
   logic [7:0] seccount_ff, nxt_seccount;
   logic [7:0] secnum_ff, nxt_secnum;
   logic [7:0] devhead_ff, nxt_devhead;
   logic [7:0] command_ff, nxt_command;
   logic [7:0] abtype_ff, nxt_abtype;
   logic ncq_en_ff, nxt_ncq_en;
   logic [7:0] status_ff, nxt_status;
   logic [7:0] error_ff, nxt_error;
   logic [31:0] mask_ff, nxt_mask;
   logic [31:0] prdata_ff, nxt_prdata;
   logic wr_acc, setup, busy, reject;
   ncqdh_pkg::ncqdh_tag_t own_tag, target_tag;

   // Known offsets; anything else answers with an error.
   function automatic logic addr_mapped(input logic [7:0] a);
      case (a)
         `NCQDH_OFF_FEATURE, `NCQDH_OFF_SECCOUNT, `NCQDH_OFF_SECNUM, `NCQDH_OFF_DEVHEAD,
         `NCQDH_OFF_COMMAND, `NCQDH_OFF_STATUS, `NCQDH_OFF_ERROR, `NCQDH_OFF_CTRL,
         `NCQDH_OFF_ABTYPE, `NCQDH_OFF_POLICY, `NCQDH_OFF_SDBMASK: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   endfunction

   // The target tag is usable only below the queue depth the device reports.
   function automatic logic tag_ok(input ncqdh_pkg::ncqdh_tag_t t);
      tag_ok = ({27'h0, t} < 32'(QUEUE_DEPTH));
   endfunction

   // Zero-wait slave: read data is captured in the setup cycle, so pready is never held low.
   assign setup = psel && !penable;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !addr_mapped(paddr);
   assign wr_acc = psel && penable && pwrite && addr_mapped(paddr);
   assign busy = (state_ff != ncqdh_pkg::st_idle);
   assign prdata = prdata_ff;

   assign own_tag = seccount_ff[`NCQDH_TAG_HI:`NCQDH_TAG_LO];
   assign target_tag = secnum_ff[`NCQDH_TAG_HI:`NCQDH_TAG_LO];

   // Every abort cause is checked together; any one is enough.
   always_comb begin
      reject = 1'b0;
      if (!ncq_en_ff) reject = 1'b1;
      if (command_ff != `NCQDH_CMD_QMGMT) reject = 1'b1;
      if (feature_ff[`NCQDH_FEAT_SUB_HI:`NCQDH_FEAT_SUB_LO] != `NCQDH_SUB_DEADLINE) begin
         reject = 1'b1;
      end
      if (target_tag == own_tag) reject = 1'b1;
      if (!tag_ok(target_tag)) reject = 1'b1;
      if ({24'h0, abtype_ff} >= 32'(ABORT_TYPES)) reject = 1'b1;
   end

   // Read data mux, sampled in the setup cycle of a read.
   always_comb begin
      nxt_prdata = prdata_ff;
      if (setup && !pwrite) begin
         case (paddr)
            `NCQDH_OFF_FEATURE: nxt_prdata = {24'h0, feature_ff};
            `NCQDH_OFF_SECCOUNT: nxt_prdata = {24'h0, seccount_ff};
            `NCQDH_OFF_SECNUM: nxt_prdata = {24'h0, secnum_ff};
            `NCQDH_OFF_DEVHEAD: nxt_prdata = {24'h0, devhead_ff};
            `NCQDH_OFF_COMMAND: nxt_prdata = {24'h0, command_ff};
            `NCQDH_OFF_STATUS: nxt_prdata = {24'h0, status_ff};
            `NCQDH_OFF_ERROR: nxt_prdata = {24'h0, error_ff};
            `NCQDH_OFF_CTRL: nxt_prdata = {31'h0, ncq_en_ff};
            `NCQDH_OFF_ABTYPE: nxt_prdata = {24'h0, abtype_ff};
            `NCQDH_OFF_POLICY: nxt_prdata = {30'h0, dl.rd_enf, dl.wr_enf};
            `NCQDH_OFF_SDBMASK: nxt_prdata = mask_ff;
            default: nxt_prdata = `NCQDH_RST_WORD;
         endcase
      end
   end

   // Shadow block writes; the command block is frozen while a command is in flight.
   always_comb begin
      nxt_feature = feature_ff;
      nxt_seccount = seccount_ff;
      nxt_secnum = secnum_ff;
      nxt_devhead = devhead_ff;
      nxt_abtype = abtype_ff;
      nxt_ncq_en = ncq_en_ff;
      if (wr_acc && !busy) begin
         case (paddr)
            `NCQDH_OFF_FEATURE: nxt_feature = pwdata[7:0];
            `NCQDH_OFF_SECCOUNT: nxt_seccount = pwdata[7:0];
            `NCQDH_OFF_SECNUM: nxt_secnum = pwdata[7:0];
            `NCQDH_OFF_DEVHEAD: nxt_devhead = pwdata[7:0];
            `NCQDH_OFF_ABTYPE: nxt_abtype = {4'h0, pwdata[`NCQDH_ABTYPE_HI:0]};
            `NCQDH_OFF_CTRL: nxt_ncq_en = pwdata[`NCQDH_CTRL_NCQ_EN];
            default: nxt_ncq_en = ncq_en_ff;
         endcase
      end
   end

   // Command sequence: a write to the command offset starts it, the FIS handshake ends it.
   always_comb begin
      nxt_state = state_ff;
      nxt_command = command_ff;
      nxt_status = status_ff;
      nxt_error = error_ff;
      nxt_mask = mask_ff;
      dl.policy_load = 1'b0;
      other_done_taken = 1'b0;
      case (state_ff)
         ncqdh_pkg::st_idle: begin
            if (wr_acc && paddr == `NCQDH_OFF_COMMAND) begin
               nxt_command = pwdata[7:0];
               nxt_status = 8'h00;
               nxt_status[`NCQDH_ST_BUSY] = 1'b1;
               nxt_error = `NCQDH_RST_BYTE;
               nxt_state = ncqdh_pkg::st_eval;
            end
         end
         ncqdh_pkg::st_eval: begin
            // Completions the engine offers ride along in this FIS, whatever the outcome.
            other_done_taken = 1'b1;
            nxt_mask = other_done_mask;
            nxt_status = 8'h00;
            nxt_status[`NCQDH_ST_READY] = 1'b1;
            nxt_status[`NCQDH_ST_SEEKDONE] = 1'b1;
            if (reject) begin
               nxt_error[`NCQDH_ER_ABORTED] = 1'b1;
               nxt_status[`NCQDH_ST_ERR] = 1'b1;
            end else begin
               nxt_mask[own_tag] = 1'b1;
               dl.policy_load = 1'b1;
            end
            nxt_state = ncqdh_pkg::st_send;
         end
         ncqdh_pkg::st_send: begin
            if (sdb_ready) begin
               nxt_state = ncqdh_pkg::st_idle;
            end
         end
         default: nxt_state = ncqdh_pkg::st_idle;
      endcase
   end

   // Registers of the decoder.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ncqdh_pkg::st_idle;
         feature_ff <= `NCQDH_RST_BYTE;
         seccount_ff <= `NCQDH_RST_BYTE;
         secnum_ff <= `NCQDH_RST_BYTE;
         devhead_ff <= `NCQDH_RST_BYTE;
         command_ff <= `NCQDH_RST_BYTE;
         abtype_ff <= `NCQDH_RST_BYTE;
         ncq_en_ff <= 1'b0;
         status_ff <= `NCQDH_RST_STATUS;
         error_ff <= `NCQDH_RST_BYTE;
         mask_ff <= `NCQDH_RST_WORD;
         prdata_ff <= `NCQDH_RST_WORD;
      end else begin
         state_ff <= nxt_state;
         feature_ff <= nxt_feature;
         seccount_ff <= nxt_seccount;
         secnum_ff <= nxt_secnum;
         devhead_ff <= nxt_devhead;
         command_ff <= nxt_command;
         abtype_ff <= nxt_abtype;
         ncq_en_ff <= nxt_ncq_en;
         status_ff <= nxt_status;
         error_ff <= nxt_error;
         mask_ff <= nxt_mask;
         prdata_ff <= nxt_prdata;
      end
   end

   // The FIS carries the registered outcome so its fields hold steady through back-pressure.
   assign sdb_valid = (state_ff == ncqdh_pkg::st_send);
   assign sdb_done_mask = mask_ff;
   assign sdb_status_flags = status_ff;
   assign sdb_error_flags = error_ff;

   // New policies come straight from the feature byte of the accepted command.
   assign dl.policy_wr = feature_ff[`NCQDH_FEAT_WDEADLINE];
   assign dl.policy_rd = feature_ff[`NCQDH_FEAT_RDEADLINE];
   assign dl.miss_valid = deadline_miss;
   assign dl.miss_write = deadline_miss_write;
   assign dl.miss_priority = deadline_miss_priority;
   assign abort_all_outstanding = dl.abort_all;

   ncqdh_deadline_mon u_mon (
      .pclk(pclk),
      .presetn(presetn),
      .dl(dl)
   );
endmodule

//--- bench/ncqdh_cmd_props.sv
// Port-level assertions for the deadline-handling command block.
`timescale 1ns/100ps
`include "ncqdh_defs.svh"
module ncqdh_cmd_props #(
   parameter int QUEUE_DEPTH = 32,
   parameter int ABORT_TYPES = 2
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB request.
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   // Queue engine and transport.
   input wire logic [31:0] other_done_mask,
   input wire logic other_done_taken,
   input wire logic sdb_valid,
   input wire logic sdb_ready,
   input wire logic [31:0] sdb_done_mask,
   input wire logic [7:0] sdb_status_flags,
   input wire logic [7:0] sdb_error_flags,
   input wire logic deadline_miss,
   input wire logic [1:0] deadline_miss_priority,
   input wire logic abort_all_outstanding
);
   // One clock domain, so clock and reset are given once.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Evaluation only follows an accepted command write.
   property p_taken;
      other_done_taken |-> $past(psel && penable && pwrite && paddr == `NCQDH_OFF_COMMAND);
   endproperty
   a_taken: assert property (p_taken) else $error("Eval without command.");
   property p_sdb_start;
      $rose(sdb_valid) |-> $past(other_done_taken);
   endproperty
   a_sdb_start: assert property (p_sdb_start) else $error("SDB without eval.");
   property p_sdb_hold;
      sdb_valid && !sdb_ready |=> sdb_valid && $stable(sdb_done_mask);
   endproperty
   a_sdb_hold: assert property (p_sdb_hold) else $error("SDB moved early.");
   property p_sdb_end;
      sdb_valid && sdb_ready |=> !sdb_valid;
   endproperty
   a_sdb_end: assert property (p_sdb_end) else $error("SDB not dropped.");
   property p_ok_flags;
      sdb_valid && !sdb_status_flags[0] |-> sdb_status_flags == 8'h50 && sdb_error_flags == 8'h00;
   endproperty
   a_ok_flags: assert property (p_ok_flags) else $error("Bad success flags.");
   property p_abt_flags;
      sdb_valid && sdb_status_flags[0] |-> sdb_status_flags == 8'h51 && sdb_error_flags == 8'h04;
   endproperty
   a_abt_flags: assert property (p_abt_flags) else $error("Bad abort flags.");
   property p_other_mask;
      $rose(sdb_valid) |-> (sdb_done_mask & $past(other_done_mask)) == $past(other_done_mask);
   endproperty
   a_other_mask: assert property (p_other_mask) else $error("Others lost.");
   property p_abort_cause;
      abort_all_outstanding |-> $past(deadline_miss && deadline_miss_priority == 2'h1);
   endproperty
   a_abort_cause: assert property (p_abort_cause) else $error("Stray abort.");
endmodule

bind ncqdh_cmd ncqdh_cmd_props #(.QUEUE_DEPTH(QUEUE_DEPTH), .ABORT_TYPES(ABORT_TYPES)) u_props (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .other_done_mask(other_done_mask), .other_done_taken(other_done_taken),
   .sdb_valid(sdb_valid), .sdb_ready(sdb_ready), .sdb_done_mask(sdb_done_mask),
   .sdb_status_flags(sdb_status_flags), .sdb_error_flags(sdb_error_flags),
   .deadline_miss(deadline_miss), .deadline_miss_priority(deadline_miss_priority),
   .abort_all_outstanding(abort_all_outstanding));

//--- bench/ncqdh_sdb_sink.sv
// Host-side model that accepts Set Device Bits requests after a chosen stall.
`timescale 1ns/100ps
module ncqdh_sdb_sink (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Request and stall length.
   input wire logic sdb_valid,
   input wire logic [3:0] stall,
   // Acceptance.
   output logic sdb_ready
);
   int wait_cnt;
   // Count waiting cycles; a fresh request restarts the count.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= 0;
      end else if (sdb_valid && !sdb_ready) begin
         wait_cnt <= wait_cnt + 1;
      end else begin
         wait_cnt <= 0;
      end
   end
   // Ready only while a request waits, so a zero stall answers at once.
   assign sdb_ready = sdb_valid && (wait_cnt >= int'(stall));
endmodule

//--- bench/testbench.sv
// Self-checking testbench for the deadline-handling command block.
`timescale 1ns/100ps
`include "ncqdh_defs.svh"
module testbench;
   localparam int QD = 16;
   localparam int AT = 2;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr, sdb_status_flags, sdb_error_flags;
   logic [31:0] pwdata, prdata, other_done_mask, sdb_done_mask, rd;
   logic other_done_taken, sdb_valid, sdb_ready, deadline_miss, deadline_miss_write;
   logic [1:0] deadline_miss_priority;
   logic abort_all_outstanding;
   logic [3:0] stall;
   logic [7:0] pol_feat [3] = '{8'h11, 8'h21, 8'h01};
   int n_errors, checks_done, ncq_en, pol_wr, pol_rd;

   ncqdh_cmd #(.QUEUE_DEPTH(QD), .ABORT_TYPES(AT)) i_dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .other_done_mask(other_done_mask),
      .other_done_taken(other_done_taken), .sdb_valid(sdb_valid), .sdb_ready(sdb_ready),
      .sdb_done_mask(sdb_done_mask), .sdb_status_flags(sdb_status_flags),
      .sdb_error_flags(sdb_error_flags), .deadline_miss(deadline_miss),
      .deadline_miss_write(deadline_miss_write), .deadline_miss_priority(deadline_miss_priority),
      .abort_all_outstanding(abort_all_outstanding));
   ncqdh_sdb_sink i_sink (.pclk(pclk), .presetn(presetn), .sdb_valid(sdb_valid),
      .stall(stall), .sdb_ready(sdb_ready));

   // Free-running 100 MHz clock.
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   // Compare one value and count it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request stands until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) n_errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Issue one command and compare the completion with the model.
   task automatic issue(input logic [7:0] f, input logic [4:0] t, input logic [4:0] tt,
         input logic [3:0] ab, input logic [7:0] c);
      logic [31:0] oth;
      int ok, n;
      oth = $urandom;
      ok = ncq_en && c == 8'h63 && f[3:0] == 4'h1 && tt != t && tt < QD && ab < AT;
      other_done_mask <= oth;
      stall <= 4'($urandom % 4);
      apb(1'b1, `NCQDH_OFF_FEATURE, {24'h0, f});
      apb(1'b1, `NCQDH_OFF_SECCOUNT, {24'h0, t, 3'h0});
      apb(1'b1, `NCQDH_OFF_SECNUM, {24'h0, tt, 3'h0});
      apb(1'b1, `NCQDH_OFF_ABTYPE, {28'h0, ab});
      apb(1'b1, `NCQDH_OFF_DEVHEAD, 32'h0000_0040);
      apb(1'b1, `NCQDH_OFF_COMMAND, {24'h0, c});
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!(sdb_valid === 1'b1 && sdb_ready === 1'b1) && n < 40);
      if (n >= 40) n_errors++;
      chk({24'h0, sdb_status_flags}, ok ? 32'h50 : 32'h51);
      chk({24'h0, sdb_error_flags}, ok ? 32'h0 : 32'h4);
      chk(sdb_done_mask, ok ? (oth | (32'h1 << t)) : oth);
      if (ok) pol_wr = f[4];
      if (ok) pol_rd = f[5];
      apb(1'b0, `NCQDH_OFF_POLICY, 32'h0);
      chk(rd, {30'h0, pol_rd[0], pol_wr[0]});
      $display("Test done: cmd %h feat %h tag %0d target_queue_tag %0d", c, f, t, tt);
   endtask

   // Report one completion-timer miss and expect an abort only when enforced.
   task automatic miss(input logic w, input logic [1:0] pr);
      int exp;
      exp = pr == 2'h1 && (w ? pol_wr : pol_rd);
      @(posedge pclk);
      deadline_miss <= 1'b1;
      deadline_miss_write <= w;
      deadline_miss_priority <= pr;
      @(posedge pclk);
      deadline_miss <= 1'b0;
      @(posedge pclk);
      chk({31'h0, abort_all_outstanding}, 32'(exp));
   endtask

   // Print the counts and the verdict, then stop.
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // The run needs about five hundred cycles; this cuts off a hang.
   initial begin
      #100_000;
      n_errors++;
      print_verdict();
   end

   // Main sequence.
   initial begin
      {presetn, psel, penable, pwrite, deadline_miss, deadline_miss_write} = 6'h0;
      {paddr, pwdata, other_done_mask, deadline_miss_priority, stall} = '0;
      {n_errors, checks_done, ncq_en, pol_wr, pol_rd} = '0;
      void'($urandom(32'h3c1d));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, `NCQDH_OFF_STATUS, 32'h0000_00ff);
      apb(1'b0, `NCQDH_OFF_STATUS, 32'h0);
      chk(rd, 32'h50);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("Test done: register access");
      issue(8'h31, 5'd3, 5'd4, 4'h0, 8'h63);
      apb(1'b1, `NCQDH_OFF_CTRL, 32'h1);
      ncq_en = 1;
      issue(8'h31, 5'd3, 5'd4, 4'h0, 8'h63);
      issue(8'h01, 5'd7, 5'd7, 4'h0, 8'h63);
      issue(8'h01, 5'd7, 5'(QD), 4'h0, 8'h63);
      issue(8'h01, 5'd7, 5'd8, 4'(AT), 8'h63);
      issue(8'h02, 5'd7, 5'd8, 4'h0, 8'h63);
      issue(8'h01, 5'd7, 5'd8, 4'h0, 8'h64);
      for (int i = 0; i < 6; i++) begin
         issue({2'h0, 2'($urandom), 4'h1}, 5'($urandom % QD), 5'($urandom),
            4'($urandom % 3), 8'h63);
      end
      foreach (pol_feat[k]) begin
         issue(pol_feat[k], 5'd2, 5'd9, 4'h0, 8'h63);
         for (int m = 0; m < 8; m++) begin
            miss(m[2], m[1:0]);
         end
         $display("Test done: deadline misses under feature %h", pol_feat[k]);
      end
      print_verdict();
   end
endmodule
